// ### bus_ctl_model.sv
`timescale 1ns/1ps
module bus_ctl_model (
   input  logic        pclk,
   input  logic        pready_r,
   input  logic [31:0] prdata_r,
   output logic        psel = 1'b0,
   output logic        penable = 1'b0,
   output logic        pwrite = 1'b0,
   output logic [7:0]  paddr = 8'h00,
   output logic [31:0] pwdata = 32'h0
);
   int tmo = 0;
   // one transfer, request held until pready seen at an edge
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (!pready_r && n < 50);
      if (n == 50) tmo++;
      q = prdata_r;
      {psel, penable} <= 2'b00;
   endtask
endmodule

// ### cmd_interp.v
// Operation
// - remote commands act like panel keys
// - switch commands: 1 on, 0 off
// - level commands set channel trigger level
// - arm commands select external arming mode
// - function command selects mode until replaced
// - single cycle, averaging switches; gate time
// - store/recall; invalid without memory option
// - fast output: eight bytes, end flag last
// - fast mode shows fast-data display message
// - fast-off returns to normal remote operation
// - identify: name, CR LF; pause measuring
// - initialize: defaults, clear low errors only
// - power-on default settings
// - reset restarts measurement, keeps hard errors
// - mask command loads service request mask
// - mask zero disables all service requests
// - cal dump: C, data, CR LF; pause
// - error query sends code, clears bit 2
// - hold mode: one result, request, wait
// - hold off: measure continuously, overwrite
// - any case; space comma semicolon terminate
// - request only on masked status rise
// - argumentless commands run on second letter
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "cmd_interp_defines.vh"
module cmd_interp #(
   parameter        HAS_MEM = 1,
   parameter [31:0] MEM_MAX = 32'h00000009,
   parameter [31:0] ID_STR  = 32'h434E5431 // arbitrary name
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata_r,
   output reg         pready_r,
   output reg         pslverr_r,
   input  wire        meas_done,
   input  wire [63:0] meas_data,
   input  wire [31:0] cal_data,
   input  wire        hw_err_valid,
   input  wire [7:0]  hw_err_code,
   input  wire        fail_in,
   input  wire        local_in,
   input  wire        no_osc_in,
   output reg  [12:0] input_flags_r,
   output reg         auto_atten_r,
   output reg  [31:0] chan_a_level_r,
   output reg  [31:0] chan_b_level_r,
   output reg  [1:0]  start_arm_r,
   output reg  [1:0]  stop_arm_r,
   output reg  [3:0]  measure_kind_r,
   output reg         one_cycle_r,
   output reg         window_avg_r,
   output reg  [31:0] window_time_r,
   output reg         math_off_r,
   output reg  [31:0] scale_r,
   output reg  [31:0] shift_r,
   output reg         store_pulse_r,
   output reg         recall_pulse_r,
   output reg  [3:0]  mem_slot_r,
   output reg         fast_out_r,
   output reg         meas_run_r,
   output reg         meas_restart_r,
   output reg         srq_r
);
   localparam [1:0] P_L1  = 2'd0;
   localparam [1:0] P_L2  = 2'd1;
   localparam [1:0] P_ARG = 2'd2;

   reg  [1:0]  pst_r;
   reg  [7:0]  c1_r;
   reg  [5:0]  code_r;
   reg  [31:0] acc_r;
   reg  [3:0]  nd_r;
   reg         neg_r;
   reg         sgn_r;
   reg         frac_r;
   reg  [7:0]  mask_r;
   reg  [7:0]  err_code_r;
   reg         error_r;
   reg         fail_r;
   reg         ready_r;
   reg         hold_r;
   reg  [7:0]  sb_prev_r;
   reg  [2:0]  str_src_r;
   reg  [3:0]  tx_idx_r;
   reg  [63:0] meas_r;

   reg  [7:0]  ch;
   reg         is_dig;
   reg         is_let;
   reg         is_term;
   reg  [5:0]  dcode;
   reg         ex_go;
   reg  [5:0]  ex_code;
   reg  [2:0]  cur_src;
   reg  [7:0]  tx_byte;
   reg         tx_last;
   reg  [7:0]  sb_now;
   reg  [31:0] sval;
   reg         int_ok;
   reg         bin_ok;

   wire setup  = psel & ~penable;
   wire access = psel & penable & pready_r;
   wire wr_cmd = access & pwrite & (paddr == `OFS_CMD);
   wire rd_tx  = access & ~pwrite & (paddr == `OFS_TALK);
   wire rd_sb  = access & ~pwrite & (paddr == `OFS_STATUS);

   // two-letter command lookup, zero when unknown
   function [5:0] cmd_decode;
      input [7:0] a;
      input [7:0] b;
      begin
         case ({a, b})
            "AA": cmd_decode = 6'd1;
            "AS": cmd_decode = 6'd2;
            "AU": cmd_decode = 6'd3;
            "AX": cmd_decode = 6'd4;
            "AZ": cmd_decode = 6'd5;
            "BA": cmd_decode = 6'd6;
            "BS": cmd_decode = 6'd7;
            "BX": cmd_decode = 6'd8;
            "BZ": cmd_decode = 6'd9;
            "CO": cmd_decode = 6'd10;
            "FI": cmd_decode = 6'd11;
            "SE": cmd_decode = 6'd12;
            "TR": cmd_decode = 6'd13;
            "AT": cmd_decode = `C_ALEV;
            "BT": cmd_decode = `C_BLEV;
            "XA": cmd_decode = `C_XSTART;
            "XO": cmd_decode = `C_XSTOP;
            "FN": cmd_decode = `C_FUNC;
            "FU": cmd_decode = `C_FUNC;
            "GS": cmd_decode = `C_ONECYC;
            "GV": cmd_decode = `C_WAVG;
            "GA": cmd_decode = `C_WTIME;
            "MD": cmd_decode = `C_MATHOFF;
            "MN": cmd_decode = `C_SCALE;
            "MO": cmd_decode = `C_SHIFT;
            "MR": cmd_decode = `C_RECALL;
            "MS": cmd_decode = `C_STORE;
            "HS": cmd_decode = `C_FAST;
            "ID": cmd_decode = `C_IDQ;
            "IN": cmd_decode = `C_INIT;
            "RE": cmd_decode = `C_ABORT;
            "TC": cmd_decode = `C_CALD;
            "TE": cmd_decode = `C_FAULTQ;
            "SM": cmd_decode = `C_MASK;
            "WA": cmd_decode = `C_HOLD;
            default: cmd_decode = `C_NONE;
         endcase
      end
   endfunction

   // character classing and execute trigger
   always @* begin
      ch = {1'b0, pwdata[6:0]};
      if (ch >= 8'h61 && ch <= 8'h7A)
         ch = ch & 8'hDF;
      is_dig  = (ch >= 8'h30) && (ch <= 8'h39);
      is_let  = (ch >= 8'h41) && (ch <= 8'h5A);
      is_term = (ch == 8'h20) || (ch == 8'h2C) || (ch == 8'h3B) ||
                (ch == 8'h0D) || (ch == 8'h0A);
      dcode   = cmd_decode(c1_r, ch);
      ex_go   = 1'b0;
      ex_code = code_r;
      if (wr_cmd && pst_r == P_L2 && dcode >= `C_IDQ &&
          dcode <= `C_FAULTQ) begin
         ex_go   = 1'b1;
         ex_code = dcode;
      end else if (wr_cmd && pst_r == P_ARG) begin
         // leading spaces wait for the number
         if (is_let || (is_term && !(ch == 8'h20 && nd_r == 4'h0
                                     && !sgn_r)))
            ex_go = 1'b1;
      end
      sval   = neg_r ? (32'h0 - acc_r) : acc_r;
      int_ok = (nd_r != 4'h0) && !neg_r;
      bin_ok = int_ok && (acc_r <= 32'h1);
   end

   // talk byte selection
   always @* begin
      sb_now = 8'h00;
      sb_now[`SB_READY] = ready_r;
      sb_now[`SB_ERR]   = error_r;
      sb_now[`SB_FAIL]  = fail_r;
      sb_now[`SB_LOCAL] = local_in;
      sb_now[`SB_NOOSC] = no_osc_in;
      cur_src = (str_src_r != `TS_NONE) ? str_src_r :
                (ready_r ? `TS_MEAS : `TS_NONE);
      tx_byte = 8'h0A;
      tx_last = 1'b0;
      case (cur_src)
         `TS_ID: begin
            tx_last = (tx_idx_r == 4'd5);
            case (tx_idx_r)
               4'd0: tx_byte = ID_STR[31:24];
               4'd1: tx_byte = ID_STR[23:16];
               4'd2: tx_byte = ID_STR[15:8];
               4'd3: tx_byte = ID_STR[7:0];
               4'd4: tx_byte = 8'h0D;
               default: tx_byte = 8'h0A;
            endcase
         end
         `TS_CAL: begin
            tx_last = (tx_idx_r == 4'd6);
            case (tx_idx_r)
               4'd0: tx_byte = 8'h43;
               4'd1: tx_byte = cal_data[31:24];
               4'd2: tx_byte = cal_data[23:16];
               4'd3: tx_byte = cal_data[15:8];
               4'd4: tx_byte = cal_data[7:0];
               4'd5: tx_byte = 8'h0D;
               default: tx_byte = 8'h0A;
            endcase
         end
         `TS_ERR: begin
            tx_last = (tx_idx_r == 4'd2);
            case (tx_idx_r)
               4'd0: tx_byte = err_code_r;
               4'd1: tx_byte = 8'h0D;
               default: tx_byte = 8'h0A;
            endcase
         end
         `TS_MEAS: begin
            // eight bytes, end flag on last
            tx_last = (tx_idx_r == 4'd7);
            tx_byte = meas_r[8'd63 - {tx_idx_r[2:0], 3'b000} -: 8];
         end
         default: tx_byte = 8'h00;
      endcase
   end

   // bus, parser, settings and talk engine
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0; pready_r <= 1'b0; pslverr_r <= 1'b0;
         pst_r <= P_L1; c1_r <= 8'h00; code_r <= `C_NONE;
         acc_r <= 32'h0; nd_r <= 4'h0; neg_r <= 1'b0;
         sgn_r <= 1'b0; frac_r <= 1'b0;
         input_flags_r <= `RST_FLAGS; auto_atten_r <= 1'b1;
         chan_a_level_r <= 32'h0; chan_b_level_r <= 32'h0;
         start_arm_r <= `RST_ARM; stop_arm_r <= `RST_ARM;
         measure_kind_r <= `RST_FUNC; one_cycle_r <= 1'b0;
         window_avg_r <= 1'b0; window_time_r <= `RST_WTIME;
         math_off_r <= 1'b0; scale_r <= `RST_SCALE;
         shift_r <= 32'h0; store_pulse_r <= 1'b0;
         recall_pulse_r <= 1'b0; mem_slot_r <= 4'h0;
         fast_out_r <= 1'b0; meas_run_r <= 1'b1;
         meas_restart_r <= 1'b0; srq_r <= 1'b0;
         mask_r <= 8'h00; err_code_r <= 8'h00; error_r <= 1'b0;
         fail_r <= 1'b0; ready_r <= 1'b0; hold_r <= 1'b0;
         sb_prev_r <= 8'h00; str_src_r <= `TS_NONE;
         tx_idx_r <= 4'h0; meas_r <= 64'h0;
      end else begin
         store_pulse_r  <= 1'b0;
         recall_pulse_r <= 1'b0;
         meas_restart_r <= 1'b0;
         // read data is fixed in the setup cycle, no wait states
         pready_r <= setup;
         if (setup) begin
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
            case (paddr)
               `OFS_CMD:    prdata_r <= {30'h0, pst_r};
               `OFS_TALK:   prdata_r <= {22'h0, cur_src != `TS_NONE,
                                         tx_last, tx_byte};
               `OFS_STATUS: prdata_r <= {24'h0, sb_now[7], srq_r,
                                         sb_now[5:0]};
               `OFS_MASK:   prdata_r <= {24'h0, mask_r};
               `OFS_ERR:    prdata_r <= {24'h0, err_code_r};
               default:     pslverr_r <= 1'b1;
            endcase
         end
         // parser state
         if (wr_cmd) begin
            case (pst_r)
               P_L1: begin
                  if (is_let) begin
                     c1_r  <= ch;
                     pst_r <= P_L2;
                  end else if (!is_term) begin
                     error_r <= 1'b1;
                     err_code_r <= `ERR_CMD;
                  end
               end
               P_L2: begin
                  pst_r <= P_L1;
                  if (dcode == `C_NONE) begin
                     error_r <= 1'b1;
                     err_code_r <= `ERR_CMD;
                  end else if (dcode < `C_IDQ || dcode > `C_FAULTQ) begin
                     pst_r <= P_ARG; code_r <= dcode;
                     acc_r <= 32'h0; nd_r <= 4'h0; neg_r <= 1'b0;
                     sgn_r <= 1'b0; frac_r <= 1'b0;
                  end
               end
               P_ARG: begin
                  if (is_dig && !frac_r) begin
                     if (nd_r == `DIG_MAX) begin
                        error_r <= 1'b1;
                        err_code_r <= `ERR_ARG;
                     end else begin
                        acc_r <= {acc_r[28:0], 3'b000} +
                                 {acc_r[30:0], 1'b0} +
                                 {28'h0, ch[3:0]};
                        nd_r  <= nd_r + 4'h1;
                     end
                  end else if ((ch == 8'h2B || ch == 8'h2D) &&
                               nd_r == 4'h0 && !sgn_r) begin
                     sgn_r <= 1'b1;
                     neg_r <= (ch == 8'h2D);
                  end else if (ch == 8'h2E) begin
                     frac_r <= 1'b1;
                  end else if (is_let) begin
                     // implied end starts the next command
                     c1_r  <= ch;
                     pst_r <= P_L2;
                  end else if (is_term) begin
                     if (ex_go)
                        pst_r <= P_L1;
                  end else if (!is_dig) begin
                     error_r <= 1'b1;
                     err_code_r <= `ERR_ARG;
                     pst_r <= P_L1;
                  end
               end
               default: pst_r <= P_L1;
            endcase
         end
         // each command acts as its panel key
         if (ex_go) begin
            if (ex_code <= `C_BIN_LAST) begin
               if (bin_ok)
                  input_flags_r[ex_code[3:0] - 4'h1] <= acc_r[0];
               else begin
                  error_r <= 1'b1; err_code_r <= `ERR_ARG;
               end
            end else begin
               case (ex_code)
                  `C_ALEV, `C_BLEV: begin
                     if (nd_r == 4'h0) begin
                        error_r <= 1'b1; err_code_r <= `ERR_ARG;
                     end else if (ex_code == `C_ALEV)
                        chan_a_level_r <= sval;
                     else
                        chan_b_level_r <= sval;
                  end
                  `C_XSTART, `C_XSTOP: begin
                     if (!int_ok || acc_r == 32'h0 || acc_r > `ARM_MAX)
                        begin
                        error_r <= 1'b1; err_code_r <= `ERR_ARG;
                     end else if (ex_code == `C_XSTART)
                        start_arm_r <= acc_r[1:0];
                     else
                        stop_arm_r <= acc_r[1:0];
                  end
                  `C_FUNC: begin
                     if (!int_ok || acc_r == 32'h0 || acc_r > `FUNC_MAX)
                        begin
                        error_r <= 1'b1; err_code_r <= `ERR_ARG;
                     end else
                        measure_kind_r <= acc_r[3:0];
                  end
                  `C_ONECYC, `C_WAVG, `C_MATHOFF, `C_FAST, `C_HOLD: begin
                     if (!bin_ok) begin
                        error_r <= 1'b1; err_code_r <= `ERR_ARG;
                     end else begin
                        case (ex_code)
                           `C_ONECYC:  one_cycle_r  <= acc_r[0];
                           `C_WAVG:    window_avg_r <= acc_r[0];
                           `C_MATHOFF: math_off_r   <= acc_r[0];
                           `C_FAST:    fast_out_r   <= acc_r[0];
                           default:    hold_r       <= acc_r[0];
                        endcase
                     end
                  end
                  `C_WTIME: begin
                     if (!int_ok || acc_r == 32'h0 ||
                         acc_r > `WTIME_MAX) begin
                        error_r <= 1'b1; err_code_r <= `ERR_ARG;
                     end else
                        window_time_r <= acc_r;
                  end
                  `C_SCALE: begin
                     if (nd_r == 4'h0 || acc_r == 32'h0) begin
                        error_r <= 1'b1; err_code_r <= `ERR_ARG;
                     end else
                        scale_r <= sval;
                  end
                  `C_SHIFT: begin
                     if (nd_r == 4'h0) begin
                        error_r <= 1'b1; err_code_r <= `ERR_ARG;
                     end else
                        shift_r <= sval;
                  end
                  `C_STORE, `C_RECALL: begin
                     if (HAS_MEM == 0 || !int_ok || acc_r > MEM_MAX)
                        begin
                        error_r <= 1'b1; err_code_r <= `ERR_ARG;
                     end else begin
                        mem_slot_r     <= acc_r[3:0];
                        store_pulse_r  <= (ex_code == `C_STORE);
                        recall_pulse_r <= (ex_code == `C_RECALL);
                     end
                  end
                  `C_MASK: begin
                     if (!int_ok || acc_r > `MASK_MAX) begin
                        error_r <= 1'b1; err_code_r <= `ERR_ARG;
                     end else
                        mask_r <= acc_r[7:0];
                  end
                  `C_IDQ: begin
                     str_src_r <= `TS_ID; tx_idx_r <= 4'h0;
                  end
                  `C_CALD: begin
                     str_src_r <= `TS_CAL; tx_idx_r <= 4'h0;
                  end
                  // send code, clear status error bit
                  `C_FAULTQ: begin
                     str_src_r <= `TS_ERR; tx_idx_r <= 4'h0;
                     error_r <= 1'b0;
                  end
                  `C_INIT: begin
                     input_flags_r <= `RST_FLAGS; auto_atten_r <= 1'b1;
                     chan_a_level_r <= 32'h0; chan_b_level_r <= 32'h0;
                     start_arm_r <= `RST_ARM; stop_arm_r <= `RST_ARM;
                     measure_kind_r <= `RST_FUNC; one_cycle_r <= 1'b0;
                     window_avg_r <= 1'b0; window_time_r <= `RST_WTIME;
                     math_off_r <= 1'b0; scale_r <= `RST_SCALE;
                     shift_r <= 32'h0; fast_out_r <= 1'b0;
                     hold_r <= 1'b0; meas_restart_r <= 1'b1;
                     if (err_code_r < `ERR_HW_MIN) begin
                        err_code_r <= 8'h00; error_r <= 1'b0;
                     end
                  end
                  `C_ABORT: meas_restart_r <= 1'b1;
                  default: begin
                     error_r <= 1'b1; err_code_r <= `ERR_CMD;
                  end
               endcase
            end
         end
         // hardware errors and failures win over clears
         if (hw_err_valid) begin
            error_r <= 1'b1; err_code_r <= hw_err_code;
         end
         if (fail_in)
            fail_r <= 1'b1;
         // talk engine pops one byte per talk read
         if (rd_tx && cur_src != `TS_NONE) begin
            tx_idx_r <= tx_last ? 4'h0 : tx_idx_r + 4'h1;
            if (tx_last && str_src_r != `TS_NONE)
               str_src_r <= `TS_NONE;
            else if (tx_last)
               ready_r <= 1'b0;
         end
         // a new result overwrites the old one
         if (meas_done) begin
            meas_r  <= meas_data;
            ready_r <= 1'b1;
            if (str_src_r == `TS_NONE)
               tx_idx_r <= 4'h0;
         end
         // hold after one result; pause while a string reply is talked
         meas_run_r <= (str_src_r == `TS_NONE) && !(hold_r && ready_r)
                       && !(ex_go && ex_code >= `C_IDQ &&
                            ex_code != `C_INIT && ex_code != `C_ABORT &&
                            ex_code <= `C_FAULTQ);
         // request on masked status rise only
         sb_prev_r <= sb_now;
         if (|(sb_now & ~sb_prev_r & mask_r & `SB_SRQ_USED))
            srq_r <= 1'b1;
         else if (rd_sb)
            srq_r <= 1'b0;
      end
   end
endmodule

// ### cmd_interp_asserts.sv
`timescale 1ns/1ps
`include "cmd_interp_defines.vh"
module cmd_interp_asserts (
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [7:0]  paddr,
   input logic        pready_r,
   input logic        meas_done,
   input logic [1:0]  start_arm_r,
   input logic [31:0] window_time_r,
   input logic        fast_out_r,
   input logic        store_pulse_r,
   input logic        meas_restart_r,
   input logic        meas_run_r
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // completed command byte write
   wire cmd_w = psel && penable && pready_r && pwrite && paddr == `OFS_CMD;
   wire kick = cmd_w || meas_done;
   a_reset_defaults: assert property ($rose(presetn) |->
      start_arm_r == 2'h2 && window_time_r == 32'h12C) else $error("dflt");
   a_arm_range: assert property (start_arm_r != 2'h0)
      else $error("arm zero");
   a_gate_range: assert property (window_time_r inside {[1:99999]})
      else $error("gate range");
   a_fast_cause: assert property ($changed(fast_out_r) |-> $past(cmd_w))
      else $error("fast change");
   a_store_pulse: assert property (store_pulse_r |->
      $past(cmd_w) ##1 !store_pulse_r) else $error("store pulse");
   a_restart_pulse: assert property (meas_restart_r |=> !meas_restart_r)
      else $error("restart pulse");
   a_pause_cause: assert property ($fell(meas_run_r) |->
      $past(kick) || $past(kick, 2)) else $error("pause");
   a_resume_cause: assert property ($rose(meas_run_r) |->
      $past(psel && penable) || $past(psel && penable, 2)) else $error("run");
   cover property (store_pulse_r);
   cover property (meas_restart_r);
   cover property ($fell(meas_run_r));
endmodule
bind cmd_interp cmd_interp_asserts u_chk (.*);

// ### cmd_interp_defines.vh
`ifndef CMD_INTERP_DEFINES_VH
`define CMD_INTERP_DEFINES_VH

// register byte offsets
`define OFS_CMD      8'h00
`define OFS_TALK     8'h04
`define OFS_STATUS   8'h08
`define OFS_MASK     8'h0C
`define OFS_ERR      8'h10

// command codes; 1..13 are input on/off switches
`define C_NONE       6'd0
`define C_BIN_LAST   6'd13
`define C_ALEV       6'd14
`define C_BLEV       6'd15
`define C_XSTART     6'd16
`define C_XSTOP      6'd17
`define C_FUNC       6'd18
`define C_ONECYC     6'd19
`define C_WAVG       6'd20
`define C_WTIME      6'd21
`define C_MATHOFF    6'd22
`define C_SCALE      6'd23
`define C_SHIFT      6'd24
`define C_RECALL     6'd25
`define C_STORE      6'd26
`define C_FAST       6'd27
`define C_IDQ        6'd28
`define C_INIT       6'd29
`define C_ABORT      6'd30
`define C_CALD       6'd31
`define C_FAULTQ     6'd32
`define C_MASK       6'd33
`define C_HOLD       6'd34

// input switch bit position and switch register width
`define IF_AUTO      2
`define IF_W         13

// power-on values
`define RST_FLAGS    13'h0004
`define RST_FUNC     4'h1
`define RST_WTIME    32'h0000012C
`define RST_SCALE    32'h00000001
`define RST_ARM      2'h2

// argument limits
`define FUNC_MAX     32'h0000000F
`define ARM_MAX      32'h00000003
`define WTIME_MAX    32'h0001869F
`define MASK_MAX     32'h000000FF
`define DIG_MAX      4'hC

// status byte layout and error classes
`define SB_READY     0
`define SB_ERR       2
`define SB_FAIL      3
`define SB_LOCAL     4
`define SB_NOOSC     5
`define SB_RQS       6
`define SB_SRQ_USED  8'h3D
`define ERR_CMD      8'h10
`define ERR_ARG      8'h20
`define ERR_HW_MIN   8'h50

// talk sources
`define TS_NONE      3'd0
`define TS_ID        3'd1
`define TS_CAL       3'd2
`define TS_ERR       3'd3
`define TS_MEAS      3'd4

`endif

// ### counter_remote_command_interpreter_bench.sv
`timescale 1ns/1ps
`include "cmd_interp_defines.vh"
module counter_remote_command_interpreter_bench;
   localparam logic [31:0] NAME_V = 32'h41424344; // arbitrary name
   localparam logic [63:0] D1 = 64'h0123456789ABCDEF;
   logic pclk = 1'b0, presetn = 1'b0, meas_done = 1'b0, local_in = 1'b0;
   logic hw_err_valid = 1'b0, fail_in = 1'b0, no_osc_in = 1'b0;
   logic psel, penable, pwrite, pready_r, pslverr_r, auto_atten_r, srq_r;
   logic one_cycle_r, window_avg_r, math_off_r, store_pulse_r, fast_out_r;
   logic recall_pulse_r, meas_run_r, meas_restart_r;
   logic [7:0] paddr, hw_err_code = 8'h00;
   logic [31:0] pwdata, prdata_r, q, cal_data = 32'h0, scale_r, shift_r;
   logic [31:0] chan_a_level_r, chan_b_level_r, window_time_r;
   logic [63:0] meas_data = 64'h0;
   logic [12:0] input_flags_r;
   logic [1:0] start_arm_r, stop_arm_r;
   logic [3:0] measure_kind_r, mem_slot_r;
   int num_errors = 0, tests_run = 0, rs_seen = 0;
   cmd_interp #(.ID_STR(NAME_V)) u_dut (.*);
   bus_ctl_model u_ctl (.*);
   initial forever #4 pclk = ~pclk;
   always @(posedge pclk) if (meas_restart_r) rs_seen++;
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic send(input string s);
      foreach (s[i]) u_ctl.xfer(1'b1, `OFS_CMD, {24'h0, s[i]}, q);
      if (u_ctl.tmo > 0) end_sim();
      repeat (2) @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a);
      u_ctl.xfer(1'b0, a, 32'h0, q);
      if (u_ctl.tmo > 0) end_sim();
   endtask
   task automatic talk(input logic [7:0] b, input logic eoi);
      rd(`OFS_TALK);
      chk(q[9:0], {1'b1, eoi, b});
   endtask
   task automatic result(input logic [63:0] d);
      @(posedge pclk);
      {meas_done, meas_data} <= {1'b1, d};
      @(posedge pclk);
      meas_done <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask
   task automatic bytes8(input logic [63:0] d);
      for (int i = 7; i >= 0; i--) talk(d[i*8 +: 8], i == 0);
   endtask
   task automatic t_defaults;
      chk({measure_kind_r, start_arm_r, stop_arm_r}, 8'h1A);
      chk({input_flags_r, window_time_r}, {13'h0004, 32'h12C});
      chk({scale_r, shift_r}, 64'h1_0000_0000);
      chk({chan_a_level_r, chan_b_level_r}, 64'h0);
      chk(auto_atten_r, 1'b1);
   endtask
   task automatic t_settings;
      send("fn7,au0 xa1;xo3,ga1000,gs1,gv1,at5,bt7,ms3,mn4,mo9,");
      chk({measure_kind_r, input_flags_r[2]}, 5'hE);
      chk({start_arm_r, stop_arm_r}, 4'h7);
      chk({window_time_r, one_cycle_r, window_avg_r}, 34'hFA3);
      chk({chan_a_level_r, chan_b_level_r}, 64'h5_0000_0007);
      chk({mem_slot_r, scale_r[3:0], shift_r[3:0]}, 12'h349);
   endtask
   task automatic t_error;
      send("XA4,");
      rd(`OFS_STATUS);
      chk({start_arm_r, q[2]}, 3'h3);
      send("TE");
      talk(`ERR_ARG, 1'b0);
      talk(8'h0D, 1'b0);
      talk(8'h0A, 1'b1);
      rd(`OFS_STATUS);
      chk(q[2], 1'b0);
      rd(`OFS_ERR);
      chk(q[7:0], `ERR_ARG);
      send("IN");
      rd(`OFS_ERR);
      chk({q[7:0], measure_kind_r, start_arm_r}, 14'h6);
      hw_err_code <= `ERR_HW_MIN;
      hw_err_valid <= 1'b1;
      @(posedge pclk) hw_err_valid <= 1'b0;
      send("IN");
      rd(`OFS_ERR);
      chk(q[7:0], `ERR_HW_MIN);
      rd(8'h14);
      chk({pslverr_r, q}, 33'h100000000);
   endtask
   task automatic t_ident;
      send("ID");
      chk(meas_run_r, 1'b0);
      for (int i = 3; i >= 0; i--) talk(NAME_V[i*8 +: 8], 1'b0);
      talk(8'h0D, 1'b0);
      talk(8'h0A, 1'b1);
      repeat (2) @(posedge pclk);
      chk(meas_run_r, 1'b1);
      cal_data <= 32'hC0FFEE12;
      send("TC");
      chk(meas_run_r, 1'b0);
      talk(8'h43, 1'b0);
      for (int i = 3; i >= 0; i--) talk(cal_data[i*8 +: 8], 1'b0);
      talk(8'h0D, 1'b0);
      talk(8'h0A, 1'b1);
      repeat (2) @(posedge pclk);
      chk(meas_run_r, 1'b1);
   endtask
   // fast output and overwrite, then hold mode
   task automatic t_results;
      send("HS1,");
      chk(fast_out_r, 1'b1);
      result(D1);
      bytes8(D1);
      send("HS0,SM16,SM0,");
      local_in <= 1'b1;
      result(~D1);
      result(D1);
      chk({fast_out_r, srq_r}, 2'b00);
      local_in <= 1'b0;
      bytes8(D1);
      send("SM1,WA1,");
      result(~D1);
      chk({meas_run_r, srq_r}, 2'b01);
      bytes8(~D1);
      rs_seen = 0;
      send("RE");
      chk(rs_seen, 1);
   endtask
   task automatic end_sim;
      num_errors += u_ctl.tmo;
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_defaults();
      t_settings();
      t_error();
      t_ident();
      t_results();
      end_sim();
   end
endmodule
